/* File: inc/fbad_pkg.sv */
//////////////////////////////////////////////////////////////////////////////
// Purpose: shared constants and types of the four-bit accumulator divider
// Assumes: 32-bit register port, one register per aligned word
// Notes:   every offset, field position and reset value is named once here
//////////////////////////////////////////////////////////////////////////////
package fbad_pkg;

	// datapath
	localparam int FBAD_WIDTH      = 4;
	localparam int FBAD_ADDR_W     = 8;
	localparam int FBAD_DATA_W     = 32;
	localparam int FBAD_EVENT_W    = 16;
	localparam int FBAD_PIN_W      = 8;

	// register offsets (byte addresses)
	localparam logic [7:0] FBAD_CTRL_OFS   = 8'h00;
	localparam logic [7:0] FBAD_STATUS_OFS = 8'h04;
	localparam logic [7:0] FBAD_EVENT_OFS  = 8'h08;
	localparam logic [7:0] FBAD_CMD_OFS    = 8'h0C;

	// control fields
	localparam int FBAD_CTRL_STEP_LSB = 0;
	localparam int FBAD_CTRL_SUB_BIT  = 4;
	localparam int FBAD_CTRL_PHLO_BIT = 5;
	localparam int FBAD_CTRL_PHHI_BIT = 6;
	localparam int FBAD_CTRL_SEL_BIT  = 7;

	// status fields
	localparam int FBAD_STAT_VALUE_LSB = 0;
	localparam int FBAD_STAT_LEVEL_LSB = 4;
	localparam int FBAD_STAT_DIR_BIT   = 8;
	localparam int FBAD_STAT_SHIFT_BIT = 9;
	localparam int FBAD_STAT_OVF_BIT   = 10;

	// command fields
	localparam int FBAD_CMD_RESTART_BIT = 0;

	// reset values
	localparam logic [3:0] FBAD_STEP_RST = 4'h1;
	localparam logic [3:0] FBAD_ACC_RST  = 4'h0;

	// numeric phase offsets of the second level output
	localparam logic [3:0] FBAD_PH_NONE = 4'h0;
	localparam logic [3:0] FBAD_PH_LO   = 4'h2;
	localparam logic [3:0] FBAD_PH_HI   = 4'h4;
	localparam logic [3:0] FBAD_PH_BOTH = 4'h8;

	// counting direction, toggled by the count-down input
	typedef enum logic [0:0] {
		FBAD_UP   = 1'h0,
		FBAD_DOWN = 1'h1
	} fbad_dir_type;

endpackage

/* File: hw/fbad_sync.sv */
//////////////////////////////////////////////////////////////////////////////
// Purpose: two-flop synchroniser for a group of pin inputs
// Assumes: pins change without regard to the clock
// Notes:   the first stage feeds only the second stage
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps
module fbad_sync import fbad_pkg::*; #(
	parameter int WIDTH = 1
) (
	input  wire logic             clock,
	input  wire logic             srst,
	input  wire logic             clock_en,
	input  wire logic [WIDTH-1:0] adder_output_select_in,
	output logic      [WIDTH-1:0] sync_out
);

	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] stable;
	} fbad_sync_state_type;

	fbad_sync_state_type state_q;
	fbad_sync_state_type state_d;

	if (WIDTH < 1) begin : g_check
		$error("fbad_sync: WIDTH must be at least one");
	end

	always_comb begin
		state_d = state_q;
		if (clock_en) begin
			state_d.meta   = adder_output_select_in;
			state_d.stable = state_q.meta;
		end
		if (srst) begin
			state_d = '0;
		end
	end

	always_ff @(posedge clock) begin
		state_q <= state_d;
	end

	assign sync_out = state_q.stable;

endmodule

/* File: hw/fbad_adder.sv */
//////////////////////////////////////////////////////////////////////////////
// Purpose: add or subtract the step word and chain carry, with wrap flag
// Assumes: purely combinational
// Notes:   in subtract mode the chain input acts as a borrow
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps
module fbad_adder import fbad_pkg::*; #(
	parameter int WIDTH = FBAD_WIDTH
) (
	input  wire logic [WIDTH-1:0] acc,
	input  wire logic [WIDTH-1:0] step,
	input  wire logic             subtract,
	input  wire logic             carry_in,
	output logic      [WIDTH-1:0] sum,
	output logic                  wrap
);

	logic [WIDTH:0] wide;

	if (WIDTH < 1) begin : g_check
		$error("fbad_adder: WIDTH must be at least one");
	end

	always_comb begin
		if (subtract) begin
			wide = {1'b0, acc} - {1'b0, step} - {{WIDTH{1'b0}}, carry_in};
		end else begin
			wide = {1'b0, acc} + {1'b0, step} + {{WIDTH{1'b0}}, carry_in};
		end
		sum  = wide[WIDTH-1:0];
		wrap = wide[WIDTH];
	end

endmodule

/* File: hw/fbad_accumulator.sv */
//////////////////////////////////////////////////////////////////////////////
// Purpose: four-bit clocked accumulator used as counter and clock divider
// Assumes: one accumulation step per enabled rising clock edge; pins
//          are synchronised, the chain input comes from the same clock
// Notes:   switch settings live in the control register
//////////////////////////////////////////////////////////////////////////////
//
// Implementation choices: strobed register access and the placing of the registers.
`timescale 1ns/1ps

//////////////////////////////////////////////////////////////////////////////
module fbad_accumulator import fbad_pkg::*; #(
	parameter int EVENT_W = FBAD_EVENT_W
) (
	input  wire logic                   clock,
	input  wire logic                   srst,
	input  wire logic                   clock_en,
	input  wire logic [FBAD_ADDR_W-1:0] reg_addr,
	input  wire logic [FBAD_DATA_W-1:0] reg_wdata,
	input  wire logic                   reg_write,
	input  wire logic                   reg_read,
	output logic      [FBAD_DATA_W-1:0] reg_rdata,
	input  wire logic [FBAD_WIDTH-1:0]  gate_in,
	input  wire logic                   shift_in,
	input  wire logic                   shift_data_in,
	input  wire logic                   sub_in,
	input  wire logic                   restart_in,
	input  wire logic                   chain_carry_in,
	output logic      [FBAD_WIDTH-1:0]  bit_out,
	output logic                        top_bit_out,
	output logic                        overflow_out,
	output logic      [FBAD_WIDTH-1:0]  level1_out,
	output logic      [FBAD_WIDTH-1:0]  level2_out
);

	//////////////////////////////////////////////////////////////////////
	// elaboration checks

	if (EVENT_W < 1 || EVENT_W > FBAD_DATA_W) begin : g_check
		$error("fbad_accumulator: EVENT_W must lie in 1..32");
	end

	//////////////////////////////////////////////////////////////////////
	// state

	typedef struct packed {
		logic [FBAD_WIDTH-1:0]  step_sw;
		logic                   sub_sw;
		logic                   phase_lo;
		logic                   phase_hi;
		logic                   adder_output_select;
		logic [FBAD_WIDTH-1:0]  acc;
		fbad_dir_type           dir;
		logic                   sub_seen;
		logic                   overflow;
		logic [EVENT_W-1:0]     events;
		logic [FBAD_DATA_W-1:0] rdata;
	} fbad_state_type;

	localparam fbad_state_type FBAD_STATE_RST = '{
		step_sw:             FBAD_STEP_RST,
		sub_sw:              1'b0,
		phase_lo:            1'b0,
		phase_hi:            1'b0,
		adder_output_select: 1'b0,
		acc:                 FBAD_ACC_RST,
		dir:                 FBAD_UP,
		sub_seen:            1'b0,
		overflow:            1'b0,
		events:              '0,
		rdata:               '0
	};

	fbad_state_type state_q;
	fbad_state_type state_d;

	//////////////////////////////////////////////////////////////////////
	// pin synchronisers

	logic [FBAD_PIN_W-1:0] pins_sync;
	logic [FBAD_WIDTH-1:0] gate_sync;
	logic                  shift_sync;
	logic                  data_sync;
	logic                  sub_sync;
	logic                  restart_sync;

	fbad_sync #(
		.WIDTH    (FBAD_PIN_W)
	) u_sync (
		.clock    (clock),
		.srst     (srst),
		.clock_en (clock_en),
		.adder_output_select_in ({restart_in, sub_in, shift_data_in, shift_in, gate_in}),
		.sync_out (pins_sync)
	);

	assign gate_sync    = pins_sync[FBAD_WIDTH-1:0];
	assign shift_sync   = pins_sync[FBAD_WIDTH];
	assign data_sync    = pins_sync[FBAD_WIDTH+1];
	assign sub_sync     = pins_sync[FBAD_WIDTH+2];
	assign restart_sync = pins_sync[FBAD_WIDTH+3];

	//////////////////////////////////////////////////////////////////////
	// adder

	logic [FBAD_WIDTH-1:0] step_word;
	logic                  count_down;
	logic [FBAD_WIDTH-1:0] sum;
	logic                  wrap;

	// a gate pin raises its bit even while the switch is down
	assign step_word  = state_q.step_sw | gate_sync;

	// the switch inverts the direction the pin has toggled to
	assign count_down = (state_q.dir == FBAD_DOWN) ^ state_q.sub_sw;

	// the chain carry enters as the lowest carry, so a stage with a zero
	// step advances once per wrap of the stage below it
	fbad_adder #(
		.WIDTH    (FBAD_WIDTH)
	) u_adder (
		.acc      (state_q.acc),
		.step     (step_word),
		.subtract (count_down),
		.carry_in (chain_carry_in),
		.sum      (sum),
		.wrap     (wrap)
	);

	//////////////////////////////////////////////////////////////////////
	// next state

	logic [FBAD_WIDTH-1:0] rotated;
	logic                  soft_restart;
	logic                  sub_rise;

	// rotate low to high; the bit wrapping round is mixed with the pin
	assign rotated  = {state_q.acc[FBAD_WIDTH-2:0],
		state_q.acc[FBAD_WIDTH-1] ^ data_sync};

	assign sub_rise = sub_sync & ~state_q.sub_seen;

	assign soft_restart = reg_write && (reg_addr == FBAD_CMD_OFS)
		&& reg_wdata[FBAD_CMD_RESTART_BIT];

	always_comb begin
		state_d = state_q;
		if (clock_en) begin
			// read data stands for one cycle only
			state_d.rdata = '0;

			if (reg_write && reg_addr == FBAD_CTRL_OFS) begin
				state_d.step_sw  = reg_wdata[FBAD_CTRL_STEP_LSB +:
					FBAD_WIDTH];
				state_d.sub_sw   = reg_wdata[FBAD_CTRL_SUB_BIT];
				state_d.phase_lo = reg_wdata[FBAD_CTRL_PHLO_BIT];
				state_d.phase_hi = reg_wdata[FBAD_CTRL_PHHI_BIT];
				state_d.adder_output_select =
					reg_wdata[FBAD_CTRL_SEL_BIT];
			end

			if (reg_read) begin
				unique case (reg_addr)
					FBAD_CTRL_OFS: begin
						state_d.rdata[FBAD_CTRL_STEP_LSB +: FBAD_WIDTH] =
							state_q.step_sw;
						state_d.rdata[FBAD_CTRL_SUB_BIT]  = state_q.sub_sw;
						state_d.rdata[FBAD_CTRL_PHLO_BIT] =
							state_q.phase_lo;
						state_d.rdata[FBAD_CTRL_PHHI_BIT] =
							state_q.phase_hi;
						state_d.rdata[FBAD_CTRL_SEL_BIT]  =
							state_q.adder_output_select;
					end
					FBAD_STATUS_OFS: begin
						state_d.rdata[FBAD_STAT_VALUE_LSB +: FBAD_WIDTH] =
							state_q.acc;
						state_d.rdata[FBAD_STAT_LEVEL_LSB +: FBAD_WIDTH] =
							level2_out;
						state_d.rdata[FBAD_STAT_DIR_BIT]   = count_down;
						state_d.rdata[FBAD_STAT_SHIFT_BIT] = shift_sync;
						state_d.rdata[FBAD_STAT_OVF_BIT]   =
							state_q.overflow;
					end
					FBAD_EVENT_OFS: begin
						state_d.rdata[EVENT_W-1:0] = state_q.events;
					end
					default: begin
						state_d.rdata = '0;
					end
				endcase
			end

			// a rising edge on the count-down pin flips direction, so a
			// wrap pulse fed back turns the ramp into a triangle
			state_d.sub_seen = sub_sync;
			if (sub_rise) begin
				unique case (state_q.dir)
					FBAD_UP:   state_d.dir = FBAD_DOWN;
					FBAD_DOWN: state_d.dir = FBAD_UP;
				endcase
			end

			if (restart_sync || soft_restart) begin
				// restart ignores the step word entirely
				state_d.acc      = FBAD_ACC_RST;
				state_d.overflow = 1'b0;
			end else if (shift_sync) begin
				state_d.acc      = rotated;
				state_d.overflow = 1'b0;
			end else begin
				// only the low bits are kept; the fifth becomes the pulse
				state_d.acc      = sum;
				state_d.overflow = wrap;
				if (wrap) begin
					state_d.events = state_q.events + 1'b1;
				end
			end
		end
		if (srst) begin
			state_d = FBAD_STATE_RST;
		end
	end

	always_ff @(posedge clock) begin
		state_q <= state_d;
	end

	//////////////////////////////////////////////////////////////////////
	// outputs

	logic [FBAD_WIDTH-1:0] value_sel;
	logic [FBAD_WIDTH-1:0] phase_ofs;

	// the unregistered path follows the synchronised pins and the chain carry at once; useful for odd
	// patterns, but it carries adder glitches to the outputs
	assign value_sel = state_q.adder_output_select ? sum : state_q.acc;

	always_comb begin
		unique case ({state_q.phase_hi, state_q.phase_lo})
			2'h0: phase_ofs = FBAD_PH_NONE;
			2'h1: phase_ofs = FBAD_PH_LO;
			2'h2: phase_ofs = FBAD_PH_HI;
			2'h3: phase_ofs = FBAD_PH_BOTH;
		endcase
	end

	// each bit output toggles at half the rate of the bit below it when
	// counting by one, so the outputs form a divider chain
	assign bit_out      = value_sel;
	assign top_bit_out  = value_sel[FBAD_WIDTH-1];
	assign level1_out   = value_sel;
	assign level2_out   = value_sel + phase_ofs;
	// the registered pulse is one clock wide when counting by one and feeds a chained stage
	assign overflow_out = state_q.adder_output_select ? wrap
		: state_q.overflow;
	assign reg_rdata    = state_q.rdata;

endmodule

/* File: test/fbad_low_stage.sv */
// Purpose: preceding counter stage that feeds the chain carry
// Assumes: shares the clock of the stage under test
// Notes:   counts by one from zero once released
`timescale 1ns/1ps
module fbad_low_stage (
	input  wire logic clock,
	input  wire logic srst,
	input  wire logic run,
	output logic      carry_out
);
	logic [3:0] cnt_q;

	always_ff @(posedge clock) begin
		if (srst || !run) begin
			cnt_q <= 4'h0;
			carry_out <= 1'h0;
		end else begin
			{carry_out, cnt_q} <= {1'h0, cnt_q} + 5'h1;
		end
	end
endmodule

/* File: test/fbad_chk_sva.sv */
// Purpose: port checker of the accumulator divider
// Assumes: control fields mirrored from register writes
// Notes:   arithmetic checked only on quiet stretches
`timescale 1ns/1ps
module fbad_chk import fbad_pkg::*; (
	input wire logic        clock,
	input wire logic        srst,
	input wire logic        clock_en,
	input wire logic [7:0]  reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic        reg_write,
	input wire logic [3:0]  gate_in,
	input wire logic        shift_in,
	input wire logic        shift_data_in,
	input wire logic        restart_in,
	input wire logic        chain_carry_in,
	input wire logic [3:0]  bit_out,
	input wire logic        top_bit_out,
	input wire logic        overflow_out,
	input wire logic [3:0]  level1_out,
	input wire logic [3:0]  level2_out
);
	logic [3:0] sw_q, pb_q, ps_q, off, sh_v;
	logic [1:0] ph_q;
	logic       sel_q, pc_q, pd_q, q0, wc, ovf_ok;
	logic [4:0] us, ds;

	assign wc = clock_en && reg_write && reg_addr == FBAD_CTRL_OFS;
	always_ff @(posedge clock) begin
		pb_q <= bit_out;
		ps_q <= sw_q | gate_in;
		pc_q <= chain_carry_in;
		pd_q <= shift_data_in;
		if (srst) begin
			sw_q <= FBAD_STEP_RST;
			ph_q <= 2'h0;
			sel_q <= 1'h0;
		end else if (wc) begin
			sw_q <= reg_wdata[3:0];
			ph_q <= reg_wdata[6:5];
			sel_q <= reg_wdata[7];
		end
	end
	// direction is not mirrored, so either way is accepted
	assign q0 = clock_en && !sel_q && !reg_write;
	assign us = {1'h0, pb_q} + {1'h0, ps_q} + 5'(pc_q);
	assign ds = {1'h0, pb_q} - {1'h0, ps_q} - 5'(pc_q);
	assign sh_v = {pb_q[2:0], pb_q[3] ^ pd_q};
	assign ovf_ok = (bit_out == us[3:0] && overflow_out == us[4])
		|| (bit_out == ds[3:0] && overflow_out == ds[4]);
	assign off = ph_q[1] ? (ph_q[0] ? FBAD_PH_BOTH : FBAD_PH_HI)
		: (ph_q[0] ? FBAD_PH_LO : FBAD_PH_NONE);
	////////////////////////////////////////////////////////////////////////
	default clocking @(posedge clock); endclocking
	default disable iff (srst);
	sequence s_add;
		(q0 && !shift_in && !restart_in && $stable(gate_in))[*4];
	endsequence
	sequence s_sh;
		(q0 && shift_in && !restart_in && $stable(shift_data_in))[*4];
	endsequence
	sequence s_rst;
		(restart_in && q0)[*3] ##1 q0;
	endsequence

	a_top_bit: assert property (top_bit_out == bit_out[3])
		else $error("top bit output differs from bit 3");
	a_level_same: assert property (level1_out == bit_out)
		else $error("first level differs from bit outputs");
	a_level2_off: assert property (level2_out == 4'(level1_out + off))
		else $error("second level offset wrong");
	a_reset_clear: assert property ($fell(srst) |-> bit_out == 4'h0)
		else $error("value not cleared by reset");
	a_restart_clr: assert property (s_rst |=> bit_out == 4'h0)
		else $error("value not cleared by restart pin");
	a_shift_rot: assert property (s_sh |=> bit_out == sh_v)
		else $error("rotation with serial data wrong");
	a_add_step: assert property (s_add |=> ovf_ok || bit_out == us[3:0])
		else $error("accumulation step wrong");
	a_ovf_wrap: assert property (s_add |=> ovf_ok)
		else $error("overflow does not match wrap");

	c_wrap: cover property (s_add ##1 overflow_out);
	c_shift: cover property (s_sh);
	c_adder_output_select: cover property (sel_q && clock_en);
endmodule

bind fbad_accumulator fbad_chk chk (.clock, .srst, .clock_en, .reg_addr,
	.reg_wdata, .reg_write, .gate_in, .shift_in, .shift_data_in,
	.restart_in, .chain_carry_in, .bit_out, .top_bit_out,
	.overflow_out, .level1_out, .level2_out);

/* File: test/tb_top.sv */
// Purpose: self-checking bench of the accumulator divider
// Assumes: clock_en high but for one freeze; pins settle three edges
// Notes:   the model plays the lower stage, the uut the upper one
`timescale 1ns/1ps
module tb_top import fbad_pkg::*; ;
	logic        clock = 1'h0, srst = 1'h1, reg_write = 1'h0;
	logic        reg_read = 1'h0, shift_in = 1'h0, shift_data_in = 1'h0;
	logic        sub_in = 1'h0, restart_in = 1'h0, low_run = 1'h0;
	logic        carry, top_bit_out, overflow_out, dn, ce = 1'h1;
	logic [7:0]  reg_addr = 8'h0;
	logic [31:0] reg_wdata = 32'h0, reg_rdata, rs = 32'hDF3CB0BB;
	logic [3:0]  gate_in = 4'h0, bit_out, level1_out, level2_out, sw, b;
	int          errors = 0, total_checks = 0, cyc_n = 0, lo = 0, gap = 0;

	initial forever #10 clock = ~clock;
	fbad_accumulator uut (.clock, .srst, .clock_en(ce), .reg_addr,
		.reg_wdata, .reg_write, .reg_read, .reg_rdata, .gate_in, .shift_in,
		.shift_data_in, .sub_in, .restart_in, .chain_carry_in(carry),
		.bit_out, .top_bit_out, .overflow_out, .level1_out, .level2_out);
	fbad_low_stage low (.clock, .srst, .run(low_run), .carry_out(carry));
	////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] nx(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// bit 4 is the wrap, a borrow when counting down
	function automatic logic [4:0] step_of(input logic [3:0] p, s,
		input logic c, d);
		return d ? {1'h0, p} - {1'h0, s} - 5'(c)
			: {1'h0, p} + {1'h0, s} + 5'(c);
	endfunction
	function automatic logic [3:0] off_of(input logic [1:0] ph);
		return ph[1] ? (ph[0] ? FBAD_PH_BOTH : FBAD_PH_HI)
			: (ph[0] ? FBAD_PH_LO : FBAD_PH_NONE);
	endfunction
	task chk(input logic [31:0] g, e);
		total_checks++;
		if (g !== e) begin
			errors++;
			$display("MISMATCH %0t got %h exp %h", $time, g, e);
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'h1;
		@(posedge clock);
		reg_write <= 1'h0;
	endtask
	task rd(input logic [7:0] a);
		@(posedge clock);
		reg_addr <= a;
		reg_read <= 1'h1;
		#1 b = bit_out;
		@(posedge clock);
		reg_read <= 1'h0;
		#1;
	endtask
	task steps(input int n, input logic [3:0] s, input logic [1:0] ph);
		logic [4:0] e;
		logic [3:0] p;
		logic       c;
		@(posedge clock);
		#1 p = bit_out;
		c = carry;
		for (int i = 0; i < n; i++) begin
			@(posedge clock);
			#1 e = step_of(p, s, c, dn);
			chk(32'({overflow_out, bit_out}), 32'(e));
			chk(32'(level2_out), 32'(4'(e[3:0] + off_of(ph))));
			chk(32'(top_bit_out), 32'(e[3]));
			chk(32'(level1_out), 32'(e[3:0]));
			p = e[3:0];
			c = carry;
			cyc_n++;
			if (overflow_out === 1'h1) begin
				gap = cyc_n - lo;
				lo = cyc_n;
			end
		end
		@(posedge clock);
	endtask
	task complete_run;
		$display("errors %0d checks %0d", errors, total_checks);
		if (errors == 0 && total_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		logic [3:0] p, e4;
		repeat (16) @(posedge clock);
		srst <= 1'h0;
		rd(FBAD_STATUS_OFS);
		// the first edge out of reset already adds the reset step word
		chk(reg_rdata, 32'({FBAD_ACC_RST + FBAD_STEP_RST,
			FBAD_ACC_RST + FBAD_STEP_RST}));
		rd(8'h10);
		chk(reg_rdata, 32'h0);
		// corners first: step one, fifteen, zero, then random words
		for (int k = 0; k < 8; k++) begin
			rs = nx(rs);
			sw = k == 0 ? 4'h1 : k == 1 ? 4'hF : k == 2 ? 4'h0 : rs[3:0];
			dn = k[0];
			wr(FBAD_CTRL_OFS, {25'h0, k[2:1], k[0], sw});
			gate_in <= k > 2 ? rs[7:4] : 4'h0;
			repeat (3) @(posedge clock);
			steps(20, sw | gate_in, k[2:1]);
		end
		wr(FBAD_CTRL_OFS, 32'h1);
		gate_in <= 4'h0;
		sub_in <= 1'h1;
		repeat (4) @(posedge clock);
		dn = 1'h1;
		steps(20, 4'h1, 2'h0);
		// a low enable must hold the count where it stands
		ce <= 1'h0;
		#1 p = bit_out;
		repeat (5) @(posedge clock);
		ce <= 1'h1;
		sub_in <= 1'h0;
		#1 chk(32'(bit_out), 32'(p));
		repeat (3) @(posedge clock);
		sub_in <= 1'h1;
		repeat (4) @(posedge clock);
		dn = 1'h0;
		rd(FBAD_STATUS_OFS);
		chk(32'(reg_rdata[3:0]), 32'(b));
		wr(FBAD_CTRL_OFS, 32'h83);
		rd(FBAD_STATUS_OFS);
		chk(32'(4'(reg_rdata[3:0] + 4'h3)), 32'(b));
		// the restart command clears the register; the adder shows +3
		wr(FBAD_CMD_OFS, 32'h1);
		#1 chk(32'(bit_out), 32'(4'(FBAD_ACC_RST + 4'h3)));
		wr(FBAD_CTRL_OFS, 32'h5);
		restart_in <= 1'h1;
		repeat (5) @(posedge clock);
		#1 chk(32'({overflow_out, bit_out}), 32'h0);
		@(posedge clock);
		restart_in <= 1'h0;
		shift_in <= 1'h1;
		for (int k = 0; k < 4; k++) begin
			rs = nx(rs);
			shift_data_in <= rs[0];
			repeat (3) @(posedge clock);
			#1 p = bit_out;
			repeat (4) begin
				@(posedge clock);
				#1 e4 = {p[2:0], p[3] ^ shift_data_in};
				chk(32'(bit_out), 32'(e4));
				p = e4;
			end
			@(posedge clock);
		end
		shift_in <= 1'h0;
		wr(FBAD_CTRL_OFS, 32'h0);
		repeat (3) @(posedge clock);
		low_run <= 1'h1;
		steps(600, 4'h0, 2'h0);
		chk(32'(gap), 32'd256);
		complete_run;
	end
endmodule
